/* pkg/rx_stats_pkg.sv */
// constants and register map of the receive statistics control bank
// Function
// - While the snapshot request bit is set, readable statistics stay frozen.
// - Counters keep counting during a snapshot; reads return values captured when it began.
// - Writing one to the parity clear bit clears the parity error flag and the bit self-clears.
// - Writing one to the clear-all bit zeroes every statistics counter at once and self-clears.
// - The paused status flag reads one exactly while the snapshot request bit is set.
// - The parity error flag sets on any counter parity error and holds until cleared by software.
// - A read/write scratch register resets to 0x09 and has no effect on counting.
// - Three read-only words return the identifier string four characters each, in order.
// - A read-only register returns a constant revision identifier and ignores writes.
// - The good octet counter adds payload bytes of error-free frames, read as two 32-bit halves.
// - The good octet counter advances by the 16-bit increment whenever its strobe is high, except in a clear-all write cycle.
// - The upper 32 bits of the frame start count read as their own register beside the lower half.
// - Only control bits 2:0 and state bits 1:0 are defined; higher bits are reserved and read zero.
package rx_stats_pkg;
  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [11:0] IDX_FRAME_START_LOW = 12'h0936;
  localparam logic [11:0] IDX_FRAME_START_HIGH = 12'h0937;
  localparam logic [11:0] IDX_REVISION = 12'h0940;
  localparam logic [11:0] IDX_SCRATCH = 12'h0941;
  localparam logic [11:0] IDX_IDENT0 = 12'h0942;
  localparam logic [11:0] IDX_IDENT1 = 12'h0943;
  localparam logic [11:0] IDX_IDENT2 = 12'h0944;
  localparam logic [11:0] IDX_CONTROL = 12'h0945;
  localparam logic [11:0] IDX_STATE = 12'h0946;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h0950;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h0951;
  localparam logic [11:0] IDX_OCTETS_LOW = 12'h0960;
  localparam logic [11:0] IDX_OCTETS_HIGH = 12'h0961;
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTL_CLEAR_ALL = 0;
  localparam int CTL_PARITY_CLR = 1;
  localparam int CTL_SNAPSHOT = 2;
  localparam int ST_PARITY = 0;
  localparam int ST_PAUSED = 1;
  localparam int IRQ_PARITY = 0;
  localparam int IRQ_CLEARED = 1;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0009;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [11:0] INDEX_RESET = 12'h000;
  localparam logic [63:0] COUNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* design/rx_statistics_control_bank.sv */
// receive statistics control bank with an AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rx_statistics_control_bank #(
  parameter logic [31:0] REVISION_ID = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] IDENT_WORD0 = 32'h4142_4344, // arbitrary value
  parameter logic [31:0] IDENT_WORD1 = 32'h4546_4748, // arbitrary value
  parameter logic [31:0] IDENT_WORD2 = 32'h494A_4B4C // arbitrary value
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic frameStartInc, // one received frame start
  input wire logic [15:0] good_octet_increment, // payload bytes to add
  input wire logic good_octet_increment_strobe, // increment valid
  input wire logic parityErrorIn, // any counter parity error
  output logic irq // level interrupt
);
  import rx_stats_pkg::*;

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  logic wrPend_ff;
  logic [11:0] wrIdx_ff;
  logic [31:0] scratch_ff;
  logic [2:0] control_ff;
  logic parityFlag_ff;
  logic [63:0] frameCount_ff;
  logic [63:0] octetCount_ff;
  logic [63:0] frameSnap_ff;
  logic [63:0] octetSnap_ff;
  logic [1:0] irqStatus_ff;
  logic [1:0] irqMask_ff;
  logic [31:0] nxt_rdata;
  logic addrPhase;
  logic [11:0] addrIdx;
  logic wrCtl;
  logic clearAll;
  logic parityClear;
  logic snapStart;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // a data-phase write hit on one register index; shared by every
  // writable register so all of them land on the same edge
  function automatic logic wrHit(input logic pend, input logic [11:0] idx,
    input logic [11:0] target);
    wrHit = pend && (idx == target);
  endfunction

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addrIdx = haddr[13:2];
  // a control write lands in the data phase, with hwdata
  assign wrCtl = wrHit(wrPend_ff, wrIdx_ff, IDX_CONTROL);
  assign clearAll = wrCtl && hwdata[CTL_CLEAR_ALL];
  assign parityClear = wrCtl && hwdata[CTL_PARITY_CLR];
  assign snapStart = wrCtl && hwdata[CTL_SNAPSHOT] && !control_ff[CTL_SNAPSHOT];

  // write intent held for the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= INDEX_RESET;
    end
    else
    begin
      wrPend_ff <= addrPhase && hwrite;
      wrIdx_ff <= addrIdx;
    end
  end

  // slave is ready from the first edge after reset, response always okay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  // scratch never touches counting
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      scratch_ff <= SCRATCH_RESET;
    else if (wrHit(wrPend_ff, wrIdx_ff, IDX_SCRATCH))
      scratch_ff <= hwdata;
  end

  // only the snapshot bit stays; clear bits pulse for the write cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      control_ff <= CONTROL_RESET;
    else if (wrCtl)
      control_ff <= {hwdata[CTL_SNAPSHOT], 2'b00};
  end

  // parity flag: a fresh error beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      parityFlag_ff <= 1'b0;
    else if (parityErrorIn)
      parityFlag_ff <= 1'b1;
    else if (parityClear)
      parityFlag_ff <= 1'b0;
  end

  // ****************************************************************
  // live counters
  // ****************************************************************
  // counters keep running during a snapshot; clear-all zeroes both
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameCount_ff <= COUNT_RESET;
      octetCount_ff <= COUNT_RESET;
    end
    else if (clearAll)
    begin
      frameCount_ff <= COUNT_RESET;
      octetCount_ff <= COUNT_RESET;
    end
    else
    begin
      if (frameStartInc)
        frameCount_ff <= frameCount_ff + 64'h0000_0000_0000_0001;
      if (good_octet_increment_strobe)
        octetCount_ff <= octetCount_ff + {48'h0000_0000_0000, good_octet_increment};
    end
  end

  // snapshot taken on the rising edge of the request bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameSnap_ff <= COUNT_RESET;
      octetSnap_ff <= COUNT_RESET;
    end
    else if (clearAll)
    begin
      frameSnap_ff <= COUNT_RESET;
      octetSnap_ff <= COUNT_RESET;
    end
    else if (snapStart)
    begin
      frameSnap_ff <= frameCount_ff;
      octetSnap_ff <= octetCount_ff;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // sticky events, write one to clear; the set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStatus_ff <= IRQ_RESET;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_PARITY && parityErrorIn) || (i == IRQ_CLEARED && clearAll))
          irqStatus_ff[i] <= 1'b1;
        else if (wrHit(wrPend_ff, wrIdx_ff, IDX_IRQ_STATUS) && hwdata[i])
          irqStatus_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqMask_ff <= IRQ_RESET;
    else if (wrHit(wrPend_ff, wrIdx_ff, IDX_IRQ_MASK))
      irqMask_ff <= hwdata[1:0];
  end

  // registered, so it lags the status bit by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irqStatus_ff & irqMask_ff);
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // frozen values while paused, live otherwise; unmapped reads zero
  always_comb
  begin
    logic [63:0] frameView;
    logic [63:0] octetView;
    frameView = control_ff[CTL_SNAPSHOT] ? frameSnap_ff : frameCount_ff;
    octetView = control_ff[CTL_SNAPSHOT] ? octetSnap_ff : octetCount_ff;
    unique case (addrIdx)
      IDX_FRAME_START_LOW: nxt_rdata = frameView[31:0];
      IDX_FRAME_START_HIGH: nxt_rdata = frameView[63:32];
      IDX_REVISION: nxt_rdata = REVISION_ID;
      IDX_SCRATCH: nxt_rdata = scratch_ff;
      IDX_IDENT0: nxt_rdata = IDENT_WORD0;
      IDX_IDENT1: nxt_rdata = IDENT_WORD1;
      IDX_IDENT2: nxt_rdata = IDENT_WORD2;
      IDX_CONTROL: nxt_rdata = {29'h0000_0000, control_ff};
      IDX_STATE: nxt_rdata = {30'h0000_0000, control_ff[CTL_SNAPSHOT], parityFlag_ff};
      IDX_IRQ_STATUS: nxt_rdata = {30'h0000_0000, irqStatus_ff};
      IDX_IRQ_MASK: nxt_rdata = {30'h0000_0000, irqMask_ff};
      IDX_OCTETS_LOW: nxt_rdata = octetView[31:0];
      IDX_OCTETS_HIGH: nxt_rdata = octetView[63:32];
      default: nxt_rdata = READ_ZERO;
    endcase
  end

  // read data captured at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= READ_ZERO;
    else if (addrPhase && !hwrite)
      hrdata <= nxt_rdata;
  end
endmodule
`default_nettype wire

/* verification/rx_stats_properties.sv */
// checker of the bank's read answers against its register rules
`timescale 1ns/1ps
`default_nettype none
module rx_stats_properties
  import rx_stats_pkg::*;
#(
  parameter logic [31:0] REVISION_ID = 32'h0000_0001,
  parameter logic [31:0] IDENT_WORD0 = 32'h0000_0000,
  parameter logic [31:0] IDENT_WORD1 = 32'h0000_0000,
  parameter logic [31:0] IDENT_WORD2 = 32'h0000_0000
) (
  input wire logic clk, // bank clock
  input wire logic rst_n, // async reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic parityErrorIn // parity event
);
  logic ctlWr_ff, snap_ff, par_ff;
  wire logic req = hsel && hready && htrans == HTRANS_NONSEQ;
  // model of the control bits; a write lands one edge after its address phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctlWr_ff <= 1'b0;
      snap_ff <= 1'b0;
      par_ff <= 1'b0;
    end
    else
    begin
      ctlWr_ff <= req && hwrite && haddr[13:2] == IDX_CONTROL;
      if (ctlWr_ff)
        snap_ff <= hwdata[CTL_SNAPSHOT];
      // a fresh error wins over a clear in the same cycle
      if (parityErrorIn)
        par_ff <= 1'b1;
      else if (ctlWr_ff && hwdata[CTL_PARITY_CLR])
        par_ff <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [11:0] idx);
    req && !hwrite && haddr[13:2] == idx;
  endsequence
  property p_rev; s_rd(IDX_REVISION) |=> hrdata == REVISION_ID; endproperty
  a_rev: assert property (p_rev) else $error("revision word wrong");
  property p_id0; s_rd(IDX_IDENT0) |=> hrdata == IDENT_WORD0; endproperty
  a_id0: assert property (p_id0) else $error("ident word 0 wrong");
  property p_id1; s_rd(IDX_IDENT1) |=> hrdata == IDENT_WORD1; endproperty
  a_id1: assert property (p_id1) else $error("ident word 1 wrong");
  property p_id2; s_rd(IDX_IDENT2) |=> hrdata == IDENT_WORD2; endproperty
  a_id2: assert property (p_id2) else $error("ident word 2 wrong");
  property p_gap; s_rd(12'h093A) |=> hrdata == READ_ZERO; endproperty
  a_gap: assert property (p_gap) else $error("reserved offset not zero");
  property p_ctl; s_rd(IDX_CONTROL) |=> hrdata[31:3] == 29'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control high bits set");
  property p_pau; s_rd(IDX_STATE) |=> hrdata[ST_PAUSED] == $past(snap_ff); endproperty
  a_pau: assert property (p_pau) else $error("paused flag wrong");
  property p_par; s_rd(IDX_STATE) |=> hrdata[ST_PARITY] == $past(par_ff); endproperty
  a_par: assert property (p_par) else $error("parity flag wrong");
endmodule
bind rx_statistics_control_bank rx_stats_properties #(.REVISION_ID(REVISION_ID),
  .IDENT_WORD0(IDENT_WORD0), .IDENT_WORD1(IDENT_WORD1), .IDENT_WORD2(IDENT_WORD2)) props_i (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .parityErrorIn(parityErrorIn));
`default_nettype wire

/* verification/rx_statistics_control_bank_tb_top.sv */
// self-checking bench of the statistics control bank
`timescale 1ns/1ps
`default_nettype none
module rx_statistics_control_bank_tb_top;
  import rx_stats_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, fsInc = 0, incStb = 0, parErr = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [15:0] incAmt = '0;
  logic hreadyout, hresp, irq;
  int n_errors = 0, comparisons = 0;
  always #2 clk = ~clk;
  rx_statistics_control_bank rx_statistics_control_bank_i (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frameStartInc(fsInc), .good_octet_increment(incAmt),
    .good_octet_increment_strobe(incStb), .parityErrorIn(parErr), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer; called just after an edge, returns just after one
  task automatic xfer(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdChk(input string n, input logic [11:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic addOct(input logic [15:0] n, input int cyc);
    incStb <= 1'b1;
    incAmt <= n;
    repeat (cyc) @(posedge clk);
    incStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    rdChk("scratch", IDX_SCRATCH, SCRATCH_RESET);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    rdChk("control", IDX_CONTROL, 32'h0);
    rdChk("state", IDX_STATE, 32'h0);
    rdChk("octLow", IDX_OCTETS_LOW, 32'h0);
    xfer(IDX_REVISION, 1'b1, 32'hFFFF_FFFF);
    rdChk("rev", IDX_REVISION, 32'h0000_0001);
    rdChk("id0", IDX_IDENT0, 32'h4142_4344);
    rdChk("id1", IDX_IDENT1, 32'h4546_4748);
    rdChk("id2", IDX_IDENT2, 32'h494A_4B4C);
    rdChk("gap", 12'h093A, 32'h0);
    xfer(IDX_SCRATCH, 1'b1, 32'hA5A5_5A5A);
    rdChk("scratch", IDX_SCRATCH, 32'hA5A5_5A5A);
  endtask
  // strobe low with an amount present must add nothing
  task automatic t_count;
    addOct(16'hFFFF, 2);
    addOct(16'h0001, 1);
    incAmt <= 16'h00FF;
    fsInc <= 1'b1;
    repeat (3) @(posedge clk);
    fsInc <= 1'b0;
    rdChk("octLow", IDX_OCTETS_LOW, 32'h0001_FFFF);
    rdChk("octHigh", IDX_OCTETS_HIGH, 32'h0);
    rdChk("fsLow", IDX_FRAME_START_LOW, 32'h3);
    rdChk("fsHigh", IDX_FRAME_START_HIGH, 32'h0);
  endtask
  task automatic t_snap;
    xfer(IDX_CONTROL, 1'b1, 32'hFFFF_FFFC);
    rdChk("state", IDX_STATE, 32'h2);
    addOct(16'h0010, 1);
    fsInc <= 1'b1;
    @(posedge clk);
    fsInc <= 1'b0;
    rdChk("octFrozen", IDX_OCTETS_LOW, 32'h0001_FFFF);
    rdChk("fsFrozen", IDX_FRAME_START_LOW, 32'h3);
    rdChk("control", IDX_CONTROL, 32'h4);
    xfer(IDX_CONTROL, 1'b1, 32'h0);
    rdChk("octLive", IDX_OCTETS_LOW, 32'h0002_000F);
    rdChk("fsLive", IDX_FRAME_START_LOW, 32'h4);
    rdChk("state", IDX_STATE, 32'h0);
  endtask
  task automatic t_parity;
    parErr <= 1'b1;
    @(posedge clk);
    parErr <= 1'b0;
    rdChk("state", IDX_STATE, 32'h1);
    chk("irqMasked", 32'h0, {31'h0, irq});
    xfer(IDX_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqOn", 32'h1, {31'h0, irq});
    xfer(IDX_CONTROL, 1'b1, 32'h2);
    rdChk("state", IDX_STATE, 32'h0);
    rdChk("control", IDX_CONTROL, 32'h0);
    xfer(IDX_IRQ_STATUS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqOff", 32'h0, {31'h0, irq});
  endtask
  task automatic t_clear;
    xfer(IDX_CONTROL, 1'b1, 32'h1);
    rdChk("octLow", IDX_OCTETS_LOW, 32'h0);
    rdChk("fsLow", IDX_FRAME_START_LOW, 32'h0);
    rdChk("control", IDX_CONTROL, 32'h0);
    rdChk("irqStat", IDX_IRQ_STATUS, 32'h2);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_count;
    t_snap;
    t_parity;
    t_clear;
    report_and_stop;
  end
  // cut a hang short well past the hundred or so cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
